/* File: bench/scp_host_model.sv */
`timescale 1ns/1ps
module scp_host_model
(
  input  wire logic        clk,
  output logic      [15:0] io_addr,
  output logic             io_wr,
  output logic             io_rd,
  output logic      [7:0]  io_wdata,
  input  wire logic [7:0]  io_rdata
);
  initial
  begin
    io_addr = 16'h0000;
    io_wr = 1'b0;
    io_rd = 1'b0;
    io_wdata = 8'h00;
  end

  // Released lines show the inverse so a late sample cannot pass by luck
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge clk);
    io_addr = a;
    io_wdata = d;
    io_wr = 1'b1;
    @(negedge clk);
    io_wr = 1'b0;
    io_addr = ~a;
    io_wdata = ~d;
  endtask

  // Read data stands for the one cycle after the strobe is taken
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(negedge clk);
    io_addr = a;
    io_rd = 1'b1;
    @(negedge clk);
    d = io_rdata;
    io_rd = 1'b0;
    io_addr = ~a;
  endtask
endmodule

/* File: bench/testbench.sv */
`timescale 1ns/1ps
module testbench;
  import scp_pkg::*;
  logic        clk = 1'b0, reset = 1'b1, turbo_pin = 1'b1, channel_check_input_n = 1'b1;
  logic        parity_error = 1'b0, refresh_cycle = 1'b0, timer2_output = 1'b0;
  logic        mgmt_mode_en = 1'b1, cpu_address_strobe_n = 1'b1, mgmt_address_strobe_n = 1'b1;
  logic        cycle_done = 1'b0, cache_miss_n = 1'b1, strap_ram_drive = 1'b0;
  logic        kbd_line20_gate = 1'b0, rf;
  logic [7:0]  irq_in = 8'h00, irq_out, io_wdata, io_rdata, d;
  logic [15:0] io_addr;
  logic        io_wr, io_rd, io_rd_hit, cpu_double_clock, source_double_clock, slot_clock;
  logic        slow_mode, timer2_gate_ctl, speaker_out, nmi_out, coproc_reset_out;
  logic        kbd_reset_request_n, ready_n, mgmt_ready_n, cache_miss, io_decode_width;
  logic        ram_drive_high, address_line_20_gate;
  int          n_mismatch = 0, checked = 0;
  int          c_cpu = 0, c_slot = 0, c_cop = 0, c_kbd = 0, c_rdy = 0, c_mrdy = 0, c_irq = 0;
  int          a, b;

  always #5 clk = ~clk;

  // Counted at the rising edge, before that edge's updates land
  always @(posedge clk)
  begin
    c_cpu += cpu_double_clock;
    c_slot += slot_clock;
    c_cop += coproc_reset_out;
    c_kbd += !kbd_reset_request_n;
    c_rdy += !ready_n;
    c_mrdy += !mgmt_ready_n;
    c_irq += irq_out[0];
  end

  scp_host_model host_i (.clk, .io_addr, .io_wr, .io_rd, .io_wdata, .io_rdata);

  scp_system_ports #(.KBD_DELAY_CYC(20)) scp_system_ports_i
  (
    .clk, .reset, .io_addr, .io_wr, .io_rd, .io_wdata, .io_rdata, .io_rd_hit, .turbo_pin,
    .cpu_double_clock, .source_double_clock, .slot_clock, .slow_mode, .channel_check_input_n,
    .parity_error, .refresh_cycle, .timer2_output, .timer2_gate_ctl, .speaker_out, .nmi_out,
    .coproc_reset_out, .kbd_reset_request_n, .mgmt_mode_en, .cpu_address_strobe_n,
    .mgmt_address_strobe_n, .cycle_done, .ready_n, .mgmt_ready_n, .cache_miss_n, .cache_miss,
    .io_decode_width, .ram_drive_high, .strap_ram_drive, .irq_in, .irq_out,
    .kbd_line20_gate, .address_line_20_gate
  );

  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic rdc(input logic [15:0] adr, input logic [7:0] e, input string nm);
    host_i.rd(adr, d);
    chk(nm, d, e);
  endtask

  task automatic ms(input logic [7:0] v);
    host_i.wr(SCP_PORT_INDEX, SCP_IDX_MISC);
    host_i.wr(SCP_PORT_DATA, v);
  endtask

  task automatic t_reset;
    host_i.rd(SCP_PORT_B, d);
    chk("pb_low", d & 8'h0f, 8'h00);
    rf = d[4];
    host_i.wr(SCP_PORT_INDEX, SCP_IDX_MISC);
    rdc(SCP_PORT_INDEX, SCP_IDX_MISC, "index");
    rdc(SCP_PORT_DATA, SCP_MS_RESET, "misc");
  endtask

  task automatic t_portb;
    timer2_output = 1'b1;
    host_i.wr(SCP_PORT_B, 8'hff);
    rdc(SCP_PORT_B, {3'b001, rf, 4'hf}, "pb_ff");
    cyc(2);
    chk("spk_on", speaker_out, 1);
    host_i.wr(SCP_PORT_B, 8'h0d);
    cyc(2);
    chk("spk_off", speaker_out, 0);
    chk("t2gate", timer2_gate_ctl, 1);
    refresh_cycle = 1'b1;
    cyc(1);
    refresh_cycle = 1'b0;
    rf = ~rf;
    rdc(SCP_PORT_B, {3'b001, rf, 4'hd}, "refresh");
    host_i.wr(SCP_PORT_B, 8'hf0);
    rdc(SCP_PORT_B, {3'b001, rf, 4'h0}, "pb_ro");
    timer2_output = 1'b0;
  endtask

  task automatic perr;
    parity_error = 1'b1;
    cyc(1);
    parity_error = 1'b0;
    cyc(3);
  endtask

  task automatic t_nmi;
    host_i.wr(SCP_PORT_NMI, 8'h00);
    perr();
    chk("nmi_par", nmi_out, 1);
    rdc(SCP_PORT_B, {3'b100, rf, 4'h0}, "par_flag");
    host_i.wr(SCP_PORT_B, 8'h04);
    cyc(3);
    chk("nmi_clr", nmi_out, 0);
    perr();
    rdc(SCP_PORT_B, {3'b000, rf, 4'h4}, "par_mask");
    channel_check_input_n = 1'b0;
    cyc(3);
    chk("nmi_ch", nmi_out, 1);
    rdc(SCP_PORT_B, {3'b010, rf, 4'h4}, "ch_flag");
    channel_check_input_n = 1'b1;
    host_i.wr(SCP_PORT_B, 8'h0c);
    rdc(SCP_PORT_B, {3'b000, rf, 4'hc}, "ch_clr");
    channel_check_input_n = 1'b0;
    cyc(3);
    chk("ch_mask", nmi_out, 0);
    channel_check_input_n = 1'b1;
    host_i.wr(SCP_PORT_NMI, 8'h80);
    host_i.wr(SCP_PORT_B, 8'h00);
    perr();
    chk("nmi_dis", nmi_out, 0);
    host_i.wr(SCP_PORT_NMI, 8'h00);
    cyc(3);
    chk("nmi_en", nmi_out, 1);
    host_i.wr(SCP_PORT_B, 8'h04);
    host_i.wr(SCP_PORT_B, 8'h00);
  endtask

  task automatic spd(input logic e, input int ec, input string nm);
    cyc(2);
    chk(nm, slow_mode, e);
    chk("src_clk", source_double_clock, 1);
    a = c_cpu;
    b = c_slot;
    cyc(8);
    chk("cpu_rate", 8'(c_cpu - a), 8'(ec));
    chk("slot_rate", 8'(c_slot - b), 8'd4);
  endtask

  task automatic t_speed;
    spd(0, 8, "fast_rst");
    host_i.wr(SCP_PORT_SLOW, 8'h00);
    spd(1, 2, "sw_slow");
    host_i.wr(SCP_PORT_FAST, 8'h5a);
    spd(0, 8, "sw_fast");
    turbo_pin = 1'b0;
    spd(1, 2, "pin_slow");
    host_i.wr(SCP_PORT_FAST, 8'h00);
    spd(1, 2, "pin_wins");
    turbo_pin = 1'b1;
    ms(8'h91);
    host_i.wr(SCP_PORT_SLOW, 8'h00);
    spd(0, 8, "ports_off");
    ms(SCP_MS_RESET);
  endtask

  task automatic t_resets;
    ms(8'h31);
    a = c_kbd;
    host_i.wr(SCP_PORT_KBD, SCP_KBD_CMD_B);
    cyc(2);
    chk("kbd_fast", kbd_reset_request_n, 0);
    cyc(650);
    chk("kbd_len", 8'(c_kbd - a == 600), 1);
    ms(SCP_MS_RESET);
    a = c_kbd;
    host_i.wr(SCP_PORT_KBD, SCP_KBD_CMD_A);
    cyc(10);
    chk("kbd_delay", kbd_reset_request_n, 1);
    cyc(650);
    chk("kbd_len2", 8'(c_kbd - a == 600), 1);
    a = c_cop;
    host_i.wr(SCP_PORT_COPRST, 8'h00);
    cyc(50);
    chk("cop_len", 8'(c_cop - a), 8'd40);
    ms(8'h51);
    a = c_cop;
    host_i.wr(SCP_PORT_COPRST, 8'h00);
    cyc(50);
    chk("cop_blk", 8'(c_cop - a), 8'd0);
    ms(SCP_MS_RESET);
  endtask

  task automatic t_gate;
    chk("gate_rst", address_line_20_gate, 0);
    rdc(SCP_PORT_A20, SCP_ALL_ONES, "gate_rd");
    cyc(2);
    chk("gate_on", address_line_20_gate, 1);
    rdc(SCP_PORT_A, 8'hfe, "pa_on");
    host_i.wr(SCP_PORT_A20, 8'h00);
    cyc(2);
    chk("gate_off", address_line_20_gate, 0);
    host_i.wr(SCP_PORT_A, 8'h02);
    cyc(2);
    chk("pa_gate", address_line_20_gate, 1);
    host_i.wr(SCP_PORT_A, 8'h00);
    kbd_line20_gate = 1'b1;
    cyc(3);
    chk("kbd_gate", address_line_20_gate, 1);
    kbd_line20_gate = 1'b0;
  endtask

  // A normal strobe when nrm is set, a management strobe otherwise
  task automatic rdy(input logic nrm, input logic er, input logic em);
    a = c_rdy;
    b = c_mrdy;
    cpu_address_strobe_n = !nrm;
    mgmt_address_strobe_n = nrm;
    cyc(1);
    cpu_address_strobe_n = 1'b1;
    mgmt_address_strobe_n = 1'b1;
    cycle_done = 1'b1;
    cyc(1);
    cycle_done = 1'b0;
    cyc(3);
    chk("rdy", 8'(c_rdy - a), 8'(er));
    chk("mrdy", 8'(c_mrdy - b), 8'(em));
  endtask

  task automatic t_misc;
    cache_miss_n = 1'b0;
    rdc(16'h0461, SCP_ALL_ONES, "dec16");
    chk("hit_un", io_rd_hit, 0);
    chk("miss_off", cache_miss, 0);
    ms(8'h1f);
    cyc(2);
    chk("miss_on", cache_miss, 1);
    chk("dec_w", io_decode_width, 1);
    chk("ram_drv", ram_drive_high, 1);
    rdc(16'h0461, {3'b000, rf, 4'h0}, "dec10");
    chk("hit_map", io_rd_hit, 1);
    rdy(0, 0, 1);
    ms(8'h03);
    rdy(0, 1, 1);
    rdy(1, 1, 0);
    mgmt_mode_en = 1'b0;
    rdy(0, 0, 0);
    mgmt_mode_en = 1'b1;
    cache_miss_n = 1'b1;
    ms(SCP_MS_RESET);
    a = c_irq;
    irq_in = 8'h01;
    cyc(5);
    irq_in = 8'h00;
    cyc(15);
    chk("glitch", 8'(c_irq - a), 8'd0);
    irq_in = 8'h01;
    cyc(20);
    chk("irq_held", irq_out[0], 1);
    // Deglitch off: a change passes after one edge
    ms(8'h10);
    irq_in = 8'h00;
    cyc(3);
    chk("irq_pass", irq_out[0], 0);
  endtask

  task automatic end_sim;
    $display("checked %0d n_mismatch %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial
  begin
    cyc(4);
    reset = 1'b0;
    t_reset();
    t_portb();
    t_nmi();
    t_speed();
    t_resets();
    t_gate();
    t_misc();
    end_sim();
  end
endmodule

/* File: verilog/scp_pkg.sv */
package scp_pkg;
  localparam logic [15:0] SCP_PORT_KBD     = 16'h0064;
  localparam logic [15:0] SCP_PORT_NMI     = 16'h0070;
  localparam logic [15:0] SCP_PORT_B       = 16'h0061;
  localparam logic [15:0] SCP_PORT_A       = 16'h0092;
  localparam logic [15:0] SCP_PORT_INDEX   = 16'h00ec;
  localparam logic [15:0] SCP_PORT_DATA    = 16'h00ed;
  localparam logic [15:0] SCP_PORT_A20     = 16'h00ee;
  localparam logic [15:0] SCP_PORT_COPRST  = 16'h00f1;
  localparam logic [15:0] SCP_PORT_SLOW    = 16'h00f4;
  localparam logic [15:0] SCP_PORT_FAST    = 16'h00f5;
  localparam logic [7:0]  SCP_IDX_MISC     = 8'h14;
  localparam logic [7:0]  SCP_KBD_CMD_A    = 8'hfc;
  localparam logic [7:0]  SCP_KBD_CMD_B    = 8'hfe;
  localparam logic [7:0]  SCP_ALL_ONES     = 8'hff;
  // misc_setup field positions
  localparam int SCP_MS_PORTS_DIS = 7;
  localparam int SCP_MS_COP_BLOCK = 6;
  localparam int SCP_MS_FAST_KBD  = 5;
  localparam int SCP_MS_RDY_MGMT  = 4;
  localparam int SCP_MS_CACHE     = 3;
  localparam int SCP_MS_RAM_DRV   = 2;
  localparam int SCP_MS_IO_WIDTH  = 1;
  localparam int SCP_MS_DEGLITCH  = 0;
  localparam logic [7:0] SCP_MS_RESET = 8'h11;
  // speaker_nmi_control field positions
  localparam int SCP_PB_PARITY   = 7;
  localparam int SCP_PB_CHANNEL  = 6;
  localparam int SCP_PB_TIMER2   = 5;
  localparam int SCP_PB_REFRESH  = 4;
  localparam int SCP_PB_CH_MASK  = 3;
  localparam int SCP_PB_PAR_MASK = 2;
  localparam int SCP_PB_SPK_GATE = 1;
  localparam int SCP_PB_T2_GATE  = 0;
  localparam logic [3:0] SCP_PB_RESET = 4'h0;
  localparam int SCP_NMI_BIT     = 7;
  localparam int SCP_PA_A20      = 1;
  localparam int SCP_PA_RST      = 0;
  // Timing
  localparam int SCP_CLK_NS         = 10;
  localparam int SCP_KBD_DELAY_NS   = 50000;
  localparam int SCP_KBD_PULSE_NS   = 6000;
  localparam int SCP_DEGLITCH_NS    = 105;
  localparam int SCP_KBD_DELAY_CYC  = SCP_KBD_DELAY_NS / SCP_CLK_NS;
  localparam int SCP_KBD_PULSE_CYC  = (SCP_KBD_PULSE_NS + SCP_CLK_NS - 1) / SCP_CLK_NS;
  localparam int SCP_DEGLITCH_CYC   = (SCP_DEGLITCH_NS + SCP_CLK_NS - 1) / SCP_CLK_NS;
  localparam int SCP_COP_PULSE_CYC  = 40;
  localparam int SCP_SLOW_DIV       = 4;
  localparam int SCP_SLOT_DIV       = 2;

  typedef enum logic [1:0]
  {
    SCP_KR_IDLE  = 2'b00,
    SCP_KR_DELAY = 2'b01,
    SCP_KR_PULSE = 2'b11
  } scp_kr_e;
endpackage

/* File: verilog/scp_system_ports.sv */
`timescale 1ns/1ps
module scp_system_ports
  import scp_pkg::*;
#(
  parameter int IRQ_W         = 8,
  parameter int SLOW_DIV      = SCP_SLOW_DIV,
  parameter int SLOT_DIV      = SCP_SLOT_DIV,
  parameter int KBD_DELAY_CYC = SCP_KBD_DELAY_CYC
)
(
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic [15:0]      io_addr,
  input  wire logic             io_wr,
  input  wire logic             io_rd,
  input  wire logic [7:0]       io_wdata,
  output logic      [7:0]       io_rdata,
  output logic                  io_rd_hit,
  input  wire logic             turbo_pin,
  output logic                  cpu_double_clock,
  output logic                  source_double_clock,
  output logic                  slot_clock,
  output logic                  slow_mode,
  input  wire logic             channel_check_input_n,
  input  wire logic             parity_error,
  input  wire logic             refresh_cycle,
  input  wire logic             timer2_output,
  output logic                  timer2_gate_ctl,
  output logic                  speaker_out,
  output logic                  nmi_out,
  output logic                  coproc_reset_out,
  output logic                  kbd_reset_request_n,
  input  wire logic             mgmt_mode_en,
  input  wire logic             cpu_address_strobe_n,
  input  wire logic             mgmt_address_strobe_n,
  input  wire logic             cycle_done,
  output logic                  ready_n,
  output logic                  mgmt_ready_n,
  input  wire logic             cache_miss_n,
  output logic                  cache_miss,
  output logic                  io_decode_width,
  output logic                  ram_drive_high,
  input  wire logic             strap_ram_drive,
  input  wire logic [IRQ_W-1:0] irq_in,
  output logic      [IRQ_W-1:0] irq_out,
  input  wire logic             kbd_line20_gate,
  output logic                  address_line_20_gate
);

  localparam int DG_W = $clog2(SCP_DEGLITCH_CYC + 1);
  localparam int KR_W = $clog2(KBD_DELAY_CYC + SCP_KBD_PULSE_CYC + 1);

  function automatic logic port_hit(input logic [15:0] a, input logic [15:0] p,
                                    input logic ten_bit);
    port_hit = ten_bit ? (a[9:0] == p[9:0]) : (a == p);
  endfunction

  logic [7:0]  misc_setup;
  logic [7:0]  config_index;
  logic [3:0]  port_b_ctl;
  logic        parity_error_flag;
  logic        channel_error_flag;
  logic        refresh_toggle;
  logic        nmi_enable;
  logic        soft_fast;
  logic        line20_fast;
  logic        port_a_reset;
  logic [7:0]  slow_cnt;
  logic [7:0]  slot_cnt;
  logic [5:0]  cop_cnt;
  logic [KR_W-1:0] kr_cnt;
  scp_kr_e     kr_state;
  logic        in_normal;
  logic        in_mgmt;
  logic [DG_W-1:0] dg_cnt [IRQ_W];

  logic ten_bit;
  logic special_ports_disable;
  logic ports_on;
  logic wr_b, wr_nmi, wr_idx, wr_data, wr_a, wr_a20, wr_f1, wr_f4, wr_f5, wr_kbd;
  logic rd_a20;

  assign ten_bit               = misc_setup[SCP_MS_IO_WIDTH];
  assign special_ports_disable = misc_setup[SCP_MS_PORTS_DIS];
  assign ports_on              = !special_ports_disable;
  assign wr_b    = io_wr && port_hit(io_addr, SCP_PORT_B, ten_bit);
  assign wr_nmi  = io_wr && port_hit(io_addr, SCP_PORT_NMI, ten_bit);
  assign wr_idx  = io_wr && port_hit(io_addr, SCP_PORT_INDEX, ten_bit);
  assign wr_data = io_wr && port_hit(io_addr, SCP_PORT_DATA, ten_bit);
  assign wr_a    = io_wr && port_hit(io_addr, SCP_PORT_A, ten_bit);
  assign wr_kbd  = io_wr && port_hit(io_addr, SCP_PORT_KBD, ten_bit);
  assign wr_a20  = io_wr && ports_on && port_hit(io_addr, SCP_PORT_A20, ten_bit);
  assign rd_a20  = io_rd && ports_on && port_hit(io_addr, SCP_PORT_A20, ten_bit);
  assign wr_f1   = io_wr && ports_on && port_hit(io_addr, SCP_PORT_COPRST, ten_bit);
  assign wr_f4   = io_wr && ports_on && port_hit(io_addr, SCP_PORT_SLOW, ten_bit);
  assign wr_f5   = io_wr && ports_on && port_hit(io_addr, SCP_PORT_FAST, ten_bit);

  // Config index and the indexed setup register
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      config_index <= 8'h00;
      misc_setup   <= SCP_MS_RESET;
      misc_setup[SCP_MS_RAM_DRV] <= strap_ram_drive;
    end
    else
    begin
      if (wr_idx)
        config_index <= io_wdata;
      if (wr_data && config_index == SCP_IDX_MISC)
        misc_setup <= io_wdata;
    end
  end

  // Speed selection; reset leaves the software request at fast
  always_ff @(posedge clk)
  begin
    if (reset)
      soft_fast <= 1'b1;
    else if (wr_f4)
      soft_fast <= 1'b0;
    else if (wr_f5 && turbo_pin)
      soft_fast <= 1'b1;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      slow_mode <= 1'b0;
    else
      slow_mode <= !turbo_pin || (ports_on && !soft_fast);
  end

  // Clock enables: the slot rate never looks at slow_mode
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      slow_cnt         <= 8'h00;
      cpu_double_clock <= 1'b0;
    end
    else if (!slow_mode || slow_cnt == 8'(SLOW_DIV - 1))
    begin
      slow_cnt         <= 8'h00;
      cpu_double_clock <= 1'b1;
    end
    else
    begin
      slow_cnt         <= slow_cnt + 8'h01;
      cpu_double_clock <= 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      slot_cnt            <= 8'h00;
      slot_clock          <= 1'b0;
      source_double_clock <= 1'b0;
    end
    else
    begin
      source_double_clock <= 1'b1;
      slot_clock          <= (slot_cnt == 8'(SLOT_DIV - 1));
      slot_cnt            <= (slot_cnt == 8'(SLOT_DIV - 1)) ? 8'h00 : slot_cnt + 8'h01;
    end
  end

  // Port B control nibble; upper bits of a write are dropped
  always_ff @(posedge clk)
  begin
    if (reset)
      port_b_ctl <= SCP_PB_RESET;
    else if (wr_b)
      port_b_ctl <= io_wdata[3:0];
  end

  // Set wins over the clearing mask write
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      parity_error_flag  <= 1'b0;
      channel_error_flag <= 1'b0;
    end
    else
    begin
      if (parity_error && !port_b_ctl[SCP_PB_PAR_MASK])
        parity_error_flag <= 1'b1;
      else if (wr_b && io_wdata[SCP_PB_PAR_MASK])
        parity_error_flag <= 1'b0;
      if (!channel_check_input_n && !port_b_ctl[SCP_PB_CH_MASK])
        channel_error_flag <= 1'b1;
      else if (wr_b && io_wdata[SCP_PB_CH_MASK])
        channel_error_flag <= 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      refresh_toggle <= 1'b0;
    else if (refresh_cycle)
      refresh_toggle <= !refresh_toggle;
  end

  // NMI stays off from reset until software enables it
  always_ff @(posedge clk)
  begin
    if (reset)
      nmi_enable <= 1'b0;
    else if (wr_nmi)
      nmi_enable <= !io_wdata[SCP_NMI_BIT];
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      nmi_out         <= 1'b0;
      speaker_out     <= 1'b0;
      timer2_gate_ctl <= 1'b0;
    end
    else
    begin
      nmi_out         <= nmi_enable && (parity_error_flag || channel_error_flag);
      speaker_out     <= timer2_output && port_b_ctl[SCP_PB_SPK_GATE];
      timer2_gate_ctl <= port_b_ctl[SCP_PB_T2_GATE];
    end
  end

  // Line 20 gate: one latch shared by the fast port and Port A bit 1
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      line20_fast  <= 1'b0;
      port_a_reset <= 1'b0;
    end
    else
    begin
      if (rd_a20)
        line20_fast <= 1'b1;
      else if (wr_a20)
        line20_fast <= 1'b0;
      else if (wr_a)
        line20_fast <= io_wdata[SCP_PA_A20];
      if (wr_a)
        port_a_reset <= io_wdata[SCP_PA_RST];
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      address_line_20_gate <= 1'b0;
    else
      address_line_20_gate <= line20_fast || kbd_line20_gate;
  end

  // Coprocessor reset pulse
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      cop_cnt          <= 6'h00;
      coproc_reset_out <= 1'b0;
    end
    else if (wr_f1 && !misc_setup[SCP_MS_COP_BLOCK])
    begin
      cop_cnt          <= 6'(SCP_COP_PULSE_CYC - 1);
      coproc_reset_out <= 1'b1;
    end
    else if (cop_cnt != 6'h00)
      cop_cnt <= cop_cnt - 6'h01;
    else
      coproc_reset_out <= 1'b0;
  end

  // Keyboard reset command: optional delay, then a low pulse
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      kr_state            <= SCP_KR_IDLE;
      kr_cnt              <= '0;
      kbd_reset_request_n <= 1'b1;
    end
    else
    begin
      case (kr_state)
        SCP_KR_IDLE:
          if (wr_kbd && (io_wdata == SCP_KBD_CMD_A || io_wdata == SCP_KBD_CMD_B))
          begin
            if (misc_setup[SCP_MS_FAST_KBD])
            begin
              kr_state            <= SCP_KR_PULSE;
              kr_cnt              <= KR_W'(SCP_KBD_PULSE_CYC - 1);
              kbd_reset_request_n <= 1'b0;
            end
            else
            begin
              kr_state <= SCP_KR_DELAY;
              kr_cnt   <= KR_W'(KBD_DELAY_CYC - 1);
            end
          end
        SCP_KR_DELAY:
          if (kr_cnt == '0)
          begin
            kr_state            <= SCP_KR_PULSE;
            kr_cnt              <= KR_W'(SCP_KBD_PULSE_CYC - 1);
            kbd_reset_request_n <= 1'b0;
          end
          else
            kr_cnt <= kr_cnt - 1'b1;
        SCP_KR_PULSE:
          if (kr_cnt == '0)
          begin
            kr_state            <= SCP_KR_IDLE;
            kbd_reset_request_n <= 1'b1;
          end
          else
            kr_cnt <= kr_cnt - 1'b1;
        default:
        begin
          kr_state            <= SCP_KR_IDLE;
          kbd_reset_request_n <= 1'b1;
        end
      endcase
    end
  end

  // Ready steering per strobe kind
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      in_normal    <= 1'b0;
      in_mgmt      <= 1'b0;
      ready_n      <= 1'b1;
      mgmt_ready_n <= 1'b1;
    end
    else
    begin
      ready_n      <= 1'b1;
      mgmt_ready_n <= 1'b1;
      if (!cpu_address_strobe_n)
        in_normal <= 1'b1;
      else if (!mgmt_address_strobe_n && mgmt_mode_en)
        in_mgmt <= 1'b1;
      else if (cycle_done)
      begin
        in_normal    <= 1'b0;
        in_mgmt      <= 1'b0;
        ready_n      <= !(in_normal || (in_mgmt && !misc_setup[SCP_MS_RDY_MGMT]));
        mgmt_ready_n <= !in_mgmt;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      cache_miss      <= 1'b0;
      io_decode_width <= 1'b0;
      ram_drive_high  <= 1'b0;
    end
    else
    begin
      cache_miss      <= misc_setup[SCP_MS_CACHE] && !cache_miss_n;
      io_decode_width <= ten_bit;
      ram_drive_high  <= misc_setup[SCP_MS_RAM_DRV];
    end
  end

  // Interrupt deglitch: a new level must hold for the full count
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      irq_out <= '0;
      for (int i = 0; i < IRQ_W; i++)
        dg_cnt[i] <= '0;
    end
    else
    begin
      for (int i = 0; i < IRQ_W; i++)
      begin
        if (!misc_setup[SCP_MS_DEGLITCH] || irq_in[i] == irq_out[i])
        begin
          irq_out[i] <= irq_in[i];
          dg_cnt[i]  <= '0;
        end
        else if (dg_cnt[i] == DG_W'(SCP_DEGLITCH_CYC - 1))
        begin
          irq_out[i] <= irq_in[i];
          dg_cnt[i]  <= '0;
        end
        else
          dg_cnt[i] <= dg_cnt[i] + 1'b1;
      end
    end
  end

  // Read path, answered one cycle after the strobe
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      io_rdata  <= 8'h00;
      io_rd_hit <= 1'b0;
    end
    else
    begin
      io_rd_hit <= 1'b0;
      io_rdata  <= SCP_ALL_ONES;
      if (io_rd)
      begin
        io_rd_hit <= 1'b1;
        if (port_hit(io_addr, SCP_PORT_B, ten_bit))
          io_rdata <= {parity_error_flag, channel_error_flag, timer2_output,
                       refresh_toggle, port_b_ctl};
        else if (port_hit(io_addr, SCP_PORT_INDEX, ten_bit))
          io_rdata <= config_index;
        else if (port_hit(io_addr, SCP_PORT_DATA, ten_bit) && config_index == SCP_IDX_MISC)
          io_rdata <= misc_setup;
        else if (port_hit(io_addr, SCP_PORT_A, ten_bit))
          io_rdata <= {6'h3f, line20_fast, port_a_reset};
        else if (!rd_a20 && !port_hit(io_addr, SCP_PORT_DATA, ten_bit))
          io_rd_hit <= 1'b0;
      end
    end
  end

  sequence s_slow_write;
    wr_f4;
  endsequence

  sequence s_slow_taken;
    !soft_fast ##1 slow_mode;
  endsequence

  property p_pin_slow;
    @(posedge clk) disable iff (reset) !turbo_pin |=> slow_mode;
  endproperty
  a_pin_slow: assert property (p_pin_slow) else $error("pin low not slow");

  property p_fast_run;
    @(posedge clk) disable iff (reset) turbo_pin && soft_fast |=> !slow_mode;
  endproperty
  a_fast_run: assert property (p_fast_run) else $error("fast not taken");

  property p_fast_write;
    @(posedge clk) disable iff (reset) wr_f5 && turbo_pin |=> soft_fast;
  endproperty
  a_fast_write: assert property (p_fast_write) else $error("F5h ignored");

  property p_slow_write;
    @(posedge clk) disable iff (reset) s_slow_write |=> s_slow_taken;
  endproperty
  a_slow_write: assert property (p_slow_write) else $error("F4h ignored");

  property p_nmi_on;
    @(posedge clk) disable iff (reset) wr_nmi && !io_wdata[SCP_NMI_BIT] |=> nmi_enable;
  endproperty
  a_nmi_on: assert property (p_nmi_on) else $error("NMI not enabled");

  property p_chan_set;
    @(posedge clk) disable iff (reset)
      !channel_check_input_n && !port_b_ctl[SCP_PB_CH_MASK] |=> channel_error_flag;
  endproperty
  a_chan_set: assert property (p_chan_set) else $error("channel flag missed");

  property p_speaker;
    @(posedge clk) disable iff (reset)
      ##1 speaker_out == ($past(timer2_output) && $past(port_b_ctl[SCP_PB_SPK_GATE]));
  endproperty
  a_speaker: assert property (p_speaker) else $error("speaker mismatch");

  property p_refresh;
    @(posedge clk) disable iff (reset) refresh_cycle |=> refresh_toggle != $past(refresh_toggle);
  endproperty
  a_refresh: assert property (p_refresh) else $error("refresh toggle stuck");

  property p_kbd_fast;
    @(posedge clk) disable iff (reset)
      kr_state == SCP_KR_IDLE && wr_kbd && io_wdata == SCP_KBD_CMD_B
      && misc_setup[SCP_MS_FAST_KBD] |=> !kbd_reset_request_n [*8];
  endproperty
  a_kbd_fast: assert property (p_kbd_fast) else $error("fast reset pulse bad");

  property p_a20_read;
    @(posedge clk) disable iff (reset) rd_a20 |=> line20_fast ##1 address_line_20_gate;
  endproperty
  a_a20_read: assert property (p_a20_read) else $error("gate not enabled");

endmodule
